// ### bench/srx_tx_model.sv
// far-side transmitter model: one word per physical lane per transfer
// assumes: bench pulses start with a word count; rst async active high
`timescale 1ns/1ps
module srx_tx_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [5:0]  n_words,
	output logic [7:0][31:0] lanes,
	output logic             valid,
	input  wire logic        ready
);
	logic [5:0]  left_q;
	logic [15:0] seq_q;

	////////////////////////////////////////////////////////////////////////
	// word and valid hold until the receiver takes them
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			left_q <= 6'h00;
			seq_q  <= 16'h0000;
		end else if (start) begin
			left_q <= n_words;
		end else if (valid && ready) begin
			left_q <= left_q - 6'h01;
			seq_q  <= seq_q + 16'h0001;
		end
	end

	assign valid = (left_q != 6'h00);

	// idle lines show the inverse so a stale word is never mistaken
	always_comb begin
		for (int l = 0; l < 8; l++) begin
			lanes[l] = {4'hA, 1'b0, 3'(l), 8'h00, seq_q};
			if (!valid)
				lanes[l] = ~lanes[l];
		end
	end
endmodule // srx_tx_model

// ### bench/tb_srx_link_regs.sv
// self-checking bench: APB register tasks and lane 1 stream through FIFO
// assumes: zero-wait APB slave, byte address four times register index
`timescale 1ns/1ps
`include "srx_consts.svh"
module tb_srx_link_regs;
	logic                     mclk;
	logic                     rst;
	srx_pkg::srx_apb_req_type req;
	logic                     pready;
	logic [31:0]              prdata;
	logic                     pslverr;
	logic [3:0]               cal;
	logic [4:0]               lat;
	logic [2:0][3:0]          term;
	logic                     rx_en;
	logic                     cks;
	logic [4:0]               fixd;
	logic [4:0]               rdpt;
	logic [2:0]               src;
	logic [7:0][31:0]         lanes;
	logic                     in_valid;
	logic                     in_ready;
	logic [31:0]              l1_data;
	logic                     l1_valid;
	logic                     l1_rdy;
	logic                     start;
	logic [5:0]               nw;
	int                       miscompares = 0;
	int                       comparisons = 0;
	int                       cyc = 0;
	int                       seq = 0;
	logic [3:0]               tc[5] = '{4'h8, 4'h8, 4'h8, 4'hE, 4'h2};
	logic [3:0]               tt[5] = '{4'h3, 4'hB, 4'h8, 4'h7, 4'hF};
	logic [3:0]               te[5] = '{4'hB, 4'h5, 4'h8, 4'hF, 4'h0};

	srx_link_regs #(.WIDTH(32), .DEPTH(16)) i_srx_link_regs (
		.mclk(mclk), .rst(rst), .apb_req(req), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .termination_cal_code(cal),
		.measured_latency_field(lat), .lane_term_value(term),
		.receiver_enable(rx_en), .check_sum_select(cks),
		.fixed_delay_field(fixd), .readout_point_field(rdpt),
		.logical_lane1_source(src), .physical_serial_input(lanes),
		.serial_in_valid(in_valid), .serial_in_ready(in_ready),
		.lane1_data(l1_data), .lane1_valid(l1_valid), .lane1_ready(l1_rdy));

	srx_tx_model i_srx_tx_model (
		.mclk(mclk), .rst(rst), .start(start), .n_words(nw),
		.lanes(lanes), .valid(in_valid), .ready(in_ready));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] adr(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] e, input logic er);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		req.pstrb <= 4'hF;
		@(posedge mclk);
		req.penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		if (!w)
			chk("prdata", e, prdata);
		chk("pslverr", {31'h0, er}, {31'h0, pslverr});
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0, 1'b0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, e, 1'b0);
	endtask

	task automatic send(input logic [5:0] n);
		start <= 1'b1;
		nw <= n;
		@(posedge mclk);
		start <= 1'b0;
	endtask

	task automatic drain(input int n, input int s);
		l1_rdy <= 1'b1;
		for (int i = 0; i < n; i++) begin
			do @(posedge mclk); while (l1_valid !== 1'b1);
			chk("lane1", {4'hA, 1'b0, 3'(s), 8'h00, 16'(seq)}, l1_data);
			seq++;
		end
		l1_rdy <= 1'b0;
	endtask

	task automatic end_sim;
		if (miscompares == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// no test needs more than a few thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim;
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		req = '0;
		cal = 4'h0;
		lat = 5'h15;
		start = 1'b0;
		nw = 6'h00;
		l1_rdy = 1'b0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (int l = 0; l < 3; l++)
			rd(adr(10'(`SRX_IDX_TRIM5 + l)), 32'h0);
		rd(adr(`SRX_IDX_GEN_CTRL), 32'h0);
		rd(adr(`SRX_IDX_LATENCY), 32'h15);
		rd(adr(`SRX_IDX_FIXED_DELAY), 32'h0);
		rd(adr(`SRX_IDX_READOUT), 32'h1F);
		rd(adr(`SRX_IDX_XBAR_0_1), 32'h08);
		chk("rdpt", 32'h1F, {27'h0, rdpt});
		chk("src", 32'h1, {29'h0, src});
		chk("rx_en", 32'h0, {31'h0, rx_en});
		lat <= 5'h0A;
		wr(adr(`SRX_IDX_LATENCY), 32'hFFFFFFFF);
		rd(adr(`SRX_IDX_LATENCY), 32'h0A);
		wr(adr(`SRX_IDX_FIXED_DELAY), 32'hFFFFFFFF);
		rd(adr(`SRX_IDX_FIXED_DELAY), 32'h1F);
		chk("fixd", 32'h1F, {27'h0, fixd});
		// read-out point keeps only the low five bits written
		wr(adr(`SRX_IDX_READOUT), 32'hFFFFFFEA);
		rd(adr(`SRX_IDX_READOUT), 32'h0A);
		chk("rdpt", 32'h0A, {27'h0, rdpt});
		wr(adr(`SRX_IDX_XBAR_0_1), 32'hFFFFFFE7);
		rd(adr(`SRX_IDX_XBAR_0_1), 32'h20);
		chk("src", 32'h4, {29'h0, src});
		wr(adr(`SRX_IDX_GEN_CTRL), 32'hFFFFFFFE);
		rd(adr(`SRX_IDX_GEN_CTRL), 32'h40);
		chk("cks", 32'h1, {31'h0, cks});
		chk("rx_en", 32'h0, {31'h0, rx_en});
		xfer(1'b1, 12'hFFC, 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 12'hB01, 32'h0, 32'h0, 1'b1);
		for (int k = 0; k < 5; k++) begin
			cal <= tc[k];
			for (int l = 0; l < 3; l++)
				wr(adr(10'(`SRX_IDX_TRIM5 + l)), {28'hFFFFFFF, tt[k]});
			rd(adr(`SRX_IDX_TRIM7), {28'h0, tt[k]});
			rd(adr(`SRX_IDX_CAL_CODE), {28'h0, tc[k]});
			for (int l = 0; l < 3; l++)
				chk("term", {28'h0, te[k]}, {28'h0, term[l]});
		end
		// trims are nonzero now, so a leak would show
		xfer(1'b0, adr(`SRX_IDX_TRIM5) | 12'h001, 32'h0, 32'h0, 1'b1);
		// bring-up only once every parameter is in place
		wr(adr(`SRX_IDX_GEN_CTRL), 32'h41);
		chk("rx_en", 32'h1, {31'h0, rx_en});
		for (int s = 0; s < 8; s++) begin
			wr(adr(`SRX_IDX_XBAR_0_1), 32'(s) << 3);
			send(6'h01);
			drain(1, s);
		end
		wr(adr(`SRX_IDX_XBAR_0_1), 32'h10);
		send(6'h11);
		do @(posedge mclk); while (in_ready !== 1'b0);
		rd(adr(`SRX_IDX_FIFO_STATUS), 32'h10);
		chk("in_ready", 32'h0, {31'h0, in_ready});
		drain(17, 2);
		rd(adr(`SRX_IDX_FIFO_STATUS), 32'h0);
		send(6'h03);
		do @(posedge mclk); while (in_valid !== 1'b0);
		rd(adr(`SRX_IDX_FIFO_STATUS), 32'h3);
		wr(adr(`SRX_IDX_GEN_CTRL), 32'h0);
		rd(adr(`SRX_IDX_FIFO_STATUS), 32'h0);
		chk("l1_valid", 32'h0, {31'h0, l1_valid});
		chk("in_ready", 32'h0, {31'h0, in_ready});
		// second reset must bring written fields back to their defaults
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(adr(`SRX_IDX_READOUT), 32'h1F);
		rd(adr(`SRX_IDX_TRIM7), 32'h0);
		chk("src", 32'h1, {29'h0, src});
		end_sim;
	end
endmodule // tb_srx_link_regs

// ### design/srx_consts.svh
// register indices, field positions, reset values of the receiver slice
// assumes: byte address on the bus is four times the register index
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

`define SRX_IDX_TRIM5        10'h2C0
`define SRX_IDX_TRIM6        10'h2C1
`define SRX_IDX_TRIM7        10'h2C2
`define SRX_IDX_GEN_CTRL     10'h300
`define SRX_IDX_LATENCY      10'h302
`define SRX_IDX_FIXED_DELAY  10'h304
`define SRX_IDX_READOUT      10'h306
`define SRX_IDX_XBAR_0_1     10'h308
`define SRX_IDX_CAL_CODE     10'h30C
`define SRX_IDX_FIFO_STATUS  10'h30E

`define SRX_TRIM_SIGN_BIT    3
`define SRX_GEN_EN_BIT       0
`define SRX_GEN_CKSUM_BIT    6
`define SRX_XBAR_LANE1_LSB   3

`define SRX_RST_TRIM         4'h0
`define SRX_RST_DELAY        5'h00
`define SRX_RST_READOUT      5'h1F
`define SRX_RST_LANE1_SRC    3'h1
`define SRX_TERM_MAX         5'h0F

`endif

// ### design/srx_fifo.sv
// synchronous FIFO with valid/ready on both sides and a flush
// assumes: one clock; DEPTH is a power of two up to 32
`timescale 1ns/1ps
module srx_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [5:0]            level
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]        mem [DEPTH];
	srx_pkg::srx_fifo_state_type st_q;
	srx_pkg::srx_fifo_state_type st_d;
	logic                    push;
	logic                    pop;

	assign in_ready  = (st_q.count != 6'(DEPTH)) && !flush;
	assign out_valid = (st_q.count != 6'h00);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[st_q.rd_ptr[AW-1:0]];
	assign level     = st_q.count;

	always_comb begin
		st_d = st_q;
		if (flush) begin
			st_d = '0;
		end else begin
			if (push)
				st_d.wr_ptr = st_q.wr_ptr + 5'h01;
			if (pop)
				st_d.rd_ptr = st_q.rd_ptr + 5'h01;
			if (push && !pop)
				st_d.count = st_q.count + 6'h01;
			else if (pop && !push)
				st_d.count = st_q.count - 6'h01;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// storage needs no reset; only words below count are ever read
	always_ff @(posedge mclk) begin
		if (push)
			mem[st_q.wr_ptr[AW-1:0]] <= in_data;
	end

endmodule // srx_fifo

// ### design/srx_link_regs.sv
// receiver configuration slice: lane trims, bring-up, latency, crossbar
// assumes: APB master at 10 MHz on mclk; calibration engine and deframer
// outside supply the base code and the measured latency
`timescale 1ns/1ps
`include "srx_consts.svh"
module srx_link_regs #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  srx_pkg::srx_apb_req_type     apb_req,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	input  wire logic [3:0]              termination_cal_code,
	input  wire logic [4:0]              measured_latency_field,
	output logic [2:0][3:0]              lane_term_value,
	output logic                         receiver_enable,
	output logic                         check_sum_select,
	output logic [4:0]                   fixed_delay_field,
	output logic [4:0]                   readout_point_field,
	output logic [2:0]                   logical_lane1_source,
	input  wire logic [7:0][WIDTH-1:0]   physical_serial_input,
	input  wire logic                    serial_in_valid,
	output logic                         serial_in_ready,
	output logic [WIDTH-1:0]             lane1_data,
	output logic                         lane1_valid,
	input  wire logic                    lane1_ready
);

	srx_pkg::srx_state_type st_q;
	srx_pkg::srx_state_type st_d;
	logic [9:0]             idx;
	logic                   aligned;
	logic                   mapped;
	logic                   setup;
	logic                   acc_wr;
	logic [31:0]            rd_word;
	logic [2:0][3:0]        adj;
	logic                   fifo_in_ready;
	logic [5:0]             fifo_level;

	////////////////////////////////////////////////////////////////////
	// bus decode

	assign idx     = apb_req.paddr[11:2];
	assign aligned = (apb_req.paddr[1:0] == 2'b00);
	assign setup   = apb_req.psel && !apb_req.penable;
	assign acc_wr  = apb_req.psel && apb_req.penable && apb_req.pwrite
		&& aligned && mapped && apb_req.pstrb[0];
	// zero wait states: read data is captured in the setup cycle
	assign pready  = 1'b1;
	assign prdata  = st_q.rdata;
	assign pslverr = st_q.err && apb_req.psel && apb_req.penable;

	always_comb begin
		mapped  = 1'b1;
		rd_word = 32'h0000_0000;
		if (idx == `SRX_IDX_TRIM5) begin
			rd_word[3:0] = st_q.trim[0];
		end else if (idx == `SRX_IDX_TRIM6) begin
			rd_word[3:0] = st_q.trim[1];
		end else if (idx == `SRX_IDX_TRIM7) begin
			rd_word[3:0] = st_q.trim[2];
		end else if (idx == `SRX_IDX_GEN_CTRL) begin
			rd_word[`SRX_GEN_EN_BIT]    = st_q.rx_en;
			rd_word[`SRX_GEN_CKSUM_BIT] = st_q.check_sum;
		end else if (idx == `SRX_IDX_LATENCY) begin
			rd_word[4:0] = measured_latency_field;
		end else if (idx == `SRX_IDX_FIXED_DELAY) begin
			rd_word[4:0] = st_q.fixed_delay;
		end else if (idx == `SRX_IDX_READOUT) begin
			rd_word[4:0] = st_q.readout;
		end else if (idx == `SRX_IDX_XBAR_0_1) begin
			rd_word[5:3] = st_q.lane1_src;
		end else if (idx == `SRX_IDX_CAL_CODE) begin
			rd_word[3:0] = termination_cal_code;
		end else if (idx == `SRX_IDX_FIFO_STATUS) begin
			rd_word[5:0] = fifo_level;
		end else begin
			mapped = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// termination trim per lane, saturated to the 4-bit code range

	for (genvar i = 0; i < 3; i++) begin : g_trim
		logic [4:0] base;
		logic [4:0] mag;
		logic [4:0] sum;
		assign base = {1'b0, termination_cal_code};
		assign mag  = {2'b00, st_q.trim[i][2:0]};
		assign sum  = base + mag;
		always_comb begin
			if (st_q.trim[i][`SRX_TRIM_SIGN_BIT]) begin
				adj[i] = (base < mag) ? 4'h0
					: 4'(base - mag);
			end else begin
				adj[i] = (sum > `SRX_TERM_MAX) ? 4'hF
					: sum[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// register state

	always_comb begin
		st_d = st_q;
		st_d.term = adj;
		if (setup) begin
			// a misaligned read must not leak the word it lands in
			st_d.rdata = (!apb_req.pwrite && aligned) ? rd_word
				: 32'h0000_0000;
			st_d.err   = !(aligned && mapped);
		end
		// only the stored bits are taken; reserved bits are dropped
		if (acc_wr) begin
			if (idx == `SRX_IDX_TRIM5) begin
				st_d.trim[0] = apb_req.pwdata[3:0];
			end else if (idx == `SRX_IDX_TRIM6) begin
				st_d.trim[1] = apb_req.pwdata[3:0];
			end else if (idx == `SRX_IDX_TRIM7) begin
				st_d.trim[2] = apb_req.pwdata[3:0];
			end else if (idx == `SRX_IDX_GEN_CTRL) begin
				st_d.rx_en = apb_req.pwdata[`SRX_GEN_EN_BIT];
				st_d.check_sum =
					apb_req.pwdata[`SRX_GEN_CKSUM_BIT];
			end else if (idx == `SRX_IDX_FIXED_DELAY) begin
				st_d.fixed_delay = apb_req.pwdata[4:0];
			end else if (idx == `SRX_IDX_READOUT) begin
				// no clamp: values above 10 are the writer's fault
				st_d.readout = apb_req.pwdata[4:0];
			end else if (idx == `SRX_IDX_XBAR_0_1) begin
				st_d.lane1_src = apb_req.pwdata[5:3];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q             <= '0;
			st_q.trim        <= {3{`SRX_RST_TRIM}};
			st_q.fixed_delay <= `SRX_RST_DELAY;
			st_q.readout     <= `SRX_RST_READOUT;
			st_q.lane1_src   <= `SRX_RST_LANE1_SRC;
		end else begin
			st_q <= st_d;
		end
	end

	assign lane_term_value      = st_q.term;
	assign receiver_enable      = st_q.rx_en;
	assign check_sum_select     = st_q.check_sum;
	assign fixed_delay_field    = st_q.fixed_delay;
	assign readout_point_field  = st_q.readout;
	assign logical_lane1_source = st_q.lane1_src;

	////////////////////////////////////////////////////////////////////
	// logical lane 1 data path; held down flushes stale words

	assign serial_in_ready = fifo_in_ready && st_q.rx_en;

	srx_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.flush     (!st_q.rx_en),
		.in_data   (physical_serial_input[st_q.lane1_src]),
		.in_valid  (serial_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (lane1_data),
		.out_valid (lane1_valid),
		.out_ready (lane1_ready),
		.level     (fifo_level)
	);

	////////////////////////////////////////////////////////////////////
	// checks

	logic rd_trim5;
	logic rd_lat;
	logic rd_cal;
	assign rd_trim5 = setup && !apb_req.pwrite && aligned
		&& idx == `SRX_IDX_TRIM5;
	assign rd_lat = setup && !apb_req.pwrite && aligned
		&& idx == `SRX_IDX_LATENCY;
	assign rd_cal = setup && !apb_req.pwrite && aligned
		&& idx == `SRX_IDX_CAL_CODE;

	property p_trim_add;
		@(posedge mclk) disable iff (rst)
		(!st_q.trim[0][3] && termination_cal_code == 4'h8
			&& st_q.trim[0][2:0] == 3'h3 && $stable(st_q.trim[0]))
			|=> lane_term_value[0] == 4'hB;
	endproperty
	a_trim_add: assert property (p_trim_add)
		else $error("lane 5 trim not added");

	property p_trim_sub;
		@(posedge mclk) disable iff (rst)
		(st_q.trim[2][3] && termination_cal_code == 4'h2
			&& st_q.trim[2][2:0] == 3'h7 && $stable(st_q.trim[2]))
			|=> lane_term_value[2] == 4'h0;
	endproperty
	a_trim_sub: assert property (p_trim_sub)
		else $error("lane 7 trim not subtracted with floor");

	property p_trim_rw;
		@(posedge mclk) disable iff (rst)
		(acc_wr && idx == `SRX_IDX_TRIM5)
			|=> st_q.trim[0] == $past(apb_req.pwdata[3:0]);
	endproperty
	a_trim_rw: assert property (p_trim_rw)
		else $error("trim readback mismatch");

	property p_rx_hold;
		@(posedge mclk) disable iff (rst)
		!receiver_enable |-> !serial_in_ready ##1 !lane1_valid;
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("receiver accepts data while held down");

	property p_latency;
		@(posedge mclk) disable iff (rst)
		rd_lat |=> prdata == {27'h0, $past(measured_latency_field)};
	endproperty
	a_latency: assert property (p_latency)
		else $error("latency readback wrong");

	property p_fixed;
		@(posedge mclk) disable iff (rst)
		(acc_wr && idx == `SRX_IDX_FIXED_DELAY)
			|=> fixed_delay_field == $past(apb_req.pwdata[4:0]);
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed delay not written");

	property p_readout;
		@(posedge mclk) disable iff (rst)
		$fell(rst) |-> readout_point_field == 5'h1F;
	endproperty
	a_readout: assert property (p_readout)
		else $error("read-out point reset wrong");

	property p_readout_wr;
		@(posedge mclk) disable iff (rst)
		(acc_wr && idx == `SRX_IDX_READOUT)
			|=> readout_point_field == $past(apb_req.pwdata[4:0]);
	endproperty
	a_readout_wr: assert property (p_readout_wr)
		else $error("read-out point not written");

	property p_src_wr;
		@(posedge mclk) disable iff (rst)
		(acc_wr && idx == `SRX_IDX_XBAR_0_1)
			|=> logical_lane1_source == $past(apb_req.pwdata[5:3]);
	endproperty
	a_src_wr: assert property (p_src_wr)
		else $error("lane 1 source not written");

	property p_misalign;
		@(posedge mclk) disable iff (rst)
		(setup && !aligned) |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_misalign: assert property (p_misalign)
		else $error("misaligned access not refused");

	property p_xbar;
		@(posedge mclk) disable iff (rst)
		(!lane1_valid && serial_in_valid && serial_in_ready)
			|=> lane1_data == $past(
				physical_serial_input[logical_lane1_source]);
	endproperty
	a_xbar: assert property (p_xbar)
		else $error("lane 1 source select wrong");

	property p_cksum;
		@(posedge mclk) disable iff (rst)
		(acc_wr && idx == `SRX_IDX_GEN_CTRL)
			|=> check_sum_select == $past(apb_req.pwdata[6])
			&& receiver_enable == $past(apb_req.pwdata[0]);
	endproperty
	a_cksum: assert property (p_cksum)
		else $error("general control bits not stored");

	property p_cal;
		@(posedge mclk) disable iff (rst)
		rd_cal |=> prdata == {28'h0, $past(termination_cal_code)};
	endproperty
	a_cal: assert property (p_cal)
		else $error("calibration code readback wrong");

	property p_resv;
		@(posedge mclk) disable iff (rst)
		rd_trim5 |=> prdata[31:4] == 28'h0;
	endproperty
	a_resv: assert property (p_resv)
		else $error("reserved bits not zero");

endmodule // srx_link_regs

// ### design/srx_pkg.sv
// types shared by the receiver slice and its bus
// assumes: 12-bit byte address, 32-bit APB data
package srx_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} srx_apb_req_type;

	typedef struct packed {
		logic [2:0][3:0] trim;
		logic            check_sum;
		logic            rx_en;
		logic [4:0]      fixed_delay;
		logic [4:0]      readout;
		logic [2:0]      lane1_src;
		logic [2:0][3:0] term;
		logic [31:0]     rdata;
		logic            err;
	} srx_state_type;

	typedef struct packed {
		logic [4:0] wr_ptr;
		logic [4:0] rd_ptr;
		logic [5:0] count;
	} srx_fifo_state_type;

endpackage
